/* File: rtl/mic_pkg.sv */
// Contract
// - Source event sets its pending flag even while its enable is low.
// - Pending flag leads to a vector jump only with its enable high.
// - Global enable low suppresses every interrupt jump.
// - Taking an interrupt pushes the next-instruction address onto the stack.
// - Program counter then loads the winning source's vector address.
// - Return from interrupt pops the saved address to resume execution; the code drops a return that meets a take or a busy state.
// - Servicing an interrupt clears the global enable, preventing nesting.
// - Requests arriving while blocked still set and keep their flags.
// - No interrupt is acknowledged while the return stack is full.
// - Simultaneous enabled requests are resolved by fixed priority.
// - Some sources have own vectors, others share a multi-function vector.
// - A pending flag that newly sets wakes the device from sleep or idle.
// - Control byte layouts: low holds timer/touch/pin plus global; high others.
// - Servicing a source clears that source's pending flag too.
// - Pin trigger field selects disabled, rising, falling or both edges.
package mic_pkg;

    localparam int          PC_W        = 13;
    localparam int          NSRC        = 7;

    // Register offsets on the plain port
    localparam logic [3:0]  OFF_CTRL_LO = 4'h0;
    localparam logic [3:0]  OFF_CTRL_HI = 4'h1;
    localparam logic [3:0]  OFF_EDGE    = 4'h2;
    localparam logic [3:0]  OFF_STATUS  = 4'h3;
    localparam logic [3:0]  OFF_MASK    = 4'h4;

    // Low control byte field positions
    localparam int          B_GIE       = 0;
    localparam int          B_PIN_EN    = 1;
    localparam int          B_TOUCH_EN  = 2;
    localparam int          B_TIMER_EN  = 3;
    localparam int          B_PIN_F     = 4;
    localparam int          B_TOUCH_F   = 5;
    localparam int          B_TIMER_F   = 6;
    // High control byte field positions
    localparam int          B_SER_EN    = 0;
    localparam int          B_TB_EN     = 1;
    localparam int          B_EE_EN     = 2;
    localparam int          B_ADC_EN    = 3;
    localparam int          B_SER_F     = 4;
    localparam int          B_TB_F      = 5;
    localparam int          B_EE_F      = 6;
    localparam int          B_ADC_F     = 7;

    localparam logic [7:0]  RST_CTRL_LO = 8'h00;
    localparam logic [7:0]  RST_CTRL_HI = 8'h00;
    localparam logic [1:0]  RST_EDGE    = 2'h0;

    // Pin edge select encodings
    localparam logic [1:0]  EDGE_OFF    = 2'h0;
    localparam logic [1:0]  EDGE_RISE   = 2'h1;
    localparam logic [1:0]  EDGE_FALL   = 2'h2;
    localparam logic [1:0]  EDGE_BOTH   = 2'h3;

    // Source index, in priority order: 0 = pin .. 6 = converter
    localparam int          S_PIN       = 0;
    localparam int          S_TOUCH     = 1;
    localparam int          S_TIMER     = 2;
    localparam int          S_SER       = 3;
    localparam int          S_TB        = 4;
    localparam int          S_EE        = 5;
    localparam int          S_ADC       = 6;

    // Vector addresses, ascending with priority order
    localparam logic [12:0] VEC_PIN     = 13'h0004;
    localparam logic [12:0] VEC_TOUCH   = 13'h0008;
    localparam logic [12:0] VEC_TIMER   = 13'h000c;
    localparam logic [12:0] VEC_MULTI   = 13'h0010;

    // Sequencer states
    typedef enum logic [1:0] {
        MIC_IDLE = 2'b00,
        MIC_PUSH = 2'b01,
        MIC_LOAD = 2'b10
    } mic_state_t;

endpackage : mic_pkg

/* File: rtl/mic_irq_ctrl.sv */
`timescale 1ns/1ps
module mic_irq_ctrl #(
    parameter int NSRC = mic_pkg::NSRC
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic [3:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    input  wire logic                    pin_in,
    input  wire logic                    touch_event,
    input  wire logic                    timer_event,
    input  wire logic                    serial_event,
    input  wire logic                    timebase_event,
    input  wire logic                    eeprom_event,
    input  wire logic                    converter_event,
    input  wire logic [mic_pkg::PC_W-1:0] cpu_pc,
    input  wire logic                    cpu_irq_ready,
    input  wire logic                    stack_full,
    input  wire logic                    return_from_irq,
    input  wire logic                    low_power,
    output logic                         stack_push,
    output logic      [mic_pkg::PC_W-1:0] push_data,
    output logic                         pc_load,
    output logic      [mic_pkg::PC_W-1:0] pc_vector,
    output logic                         stack_pop,
    output logic                         wake_up,
    output logic                         irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mic_pkg::mic_state_t       st;
        logic [NSRC-1:0]           flag;
        logic [NSRC-1:0]           en;
        logic                      gie;
        logic [1:0]                edge_sel;
        logic [NSRC-1:0]           sticky;
        logic [NSRC-1:0]           mask;
        logic [2:0]                win;
        logic [1:0]                pin_sync;
        logic                      pin_last;
        logic [7:0]                rdata;
        logic                      push;
        logic [mic_pkg::PC_W-1:0]  pdata;
        logic                      load;
        logic [mic_pkg::PC_W-1:0]  vec;
        logic                      pop;
        logic                      wake;
        logic                      irq;
    } mic_reg_t;

    // Whole state in one word: registered copy and its next value
    mic_reg_t r_q;
    mic_reg_t r_d;

    // Vector for a source; pin, touch, timer own one, rest share one
    function automatic logic [mic_pkg::PC_W-1:0] mic_vec(
        input logic [2:0] s
    );
        case (s)
            3'h0:    mic_vec = mic_pkg::VEC_PIN;
            3'h1:    mic_vec = mic_pkg::VEC_TOUCH;
            3'h2:    mic_vec = mic_pkg::VEC_TIMER;
            default: mic_vec = mic_pkg::VEC_MULTI;
        endcase
    endfunction : mic_vec

    // Lowest index request wins, which is the lowest vector
    function automatic logic [2:0] mic_pick(input logic [NSRC-1:0] v);
        logic [2:0] p;
        p = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--)
            if (v[i])
                p = 3'(i);
        mic_pick = p;
    endfunction : mic_pick

    // Helper terms of the next-state logic
    logic [NSRC-1:0] ev;
    logic [NSRC-1:0] req;
    logic            pin_edge;
    logic [7:0]      lo_v;
    logic [7:0]      hi_v;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        r_d          = r_q;
        r_d.push     = 1'b0;
        r_d.load     = 1'b0;
        r_d.pop      = 1'b0;
        r_d.rdata    = 8'h00;
        r_d.pin_sync = {r_q.pin_sync[0], pin_in};
        r_d.pin_last = r_q.pin_sync[1];

        // Pin edge detect on the synchronised level
        case (r_q.edge_sel)
            mic_pkg::EDGE_RISE: pin_edge = r_q.pin_sync[1] & ~r_q.pin_last;
            mic_pkg::EDGE_FALL: pin_edge = ~r_q.pin_sync[1] & r_q.pin_last;
            mic_pkg::EDGE_BOTH: pin_edge = r_q.pin_sync[1] ^ r_q.pin_last;
            default:            pin_edge = 1'b0;
        endcase

        ev = {converter_event, eeprom_event, timebase_event, serial_event,
              timer_event, touch_event, pin_edge};

        lo_v = {1'b0, r_q.flag[mic_pkg::S_TIMER], r_q.flag[mic_pkg::S_TOUCH],
                r_q.flag[mic_pkg::S_PIN], r_q.en[mic_pkg::S_TIMER],
                r_q.en[mic_pkg::S_TOUCH], r_q.en[mic_pkg::S_PIN],
                r_q.gie};
        hi_v = {r_q.flag[mic_pkg::S_ADC], r_q.flag[mic_pkg::S_EE],
                r_q.flag[mic_pkg::S_TB], r_q.flag[mic_pkg::S_SER],
                r_q.en[mic_pkg::S_ADC], r_q.en[mic_pkg::S_EE],
                r_q.en[mic_pkg::S_TB], r_q.en[mic_pkg::S_SER]};

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                mic_pkg::OFF_CTRL_LO:
                begin
                    r_d.gie = reg_wdata[mic_pkg::B_GIE];
                    r_d.en[mic_pkg::S_PIN]    = reg_wdata[mic_pkg::B_PIN_EN];
                    r_d.en[mic_pkg::S_TOUCH]  = reg_wdata[mic_pkg::B_TOUCH_EN];
                    r_d.en[mic_pkg::S_TIMER]  = reg_wdata[mic_pkg::B_TIMER_EN];
                    r_d.flag[mic_pkg::S_PIN]  = reg_wdata[mic_pkg::B_PIN_F];
                    r_d.flag[mic_pkg::S_TOUCH]= reg_wdata[mic_pkg::B_TOUCH_F];
                    r_d.flag[mic_pkg::S_TIMER]= reg_wdata[mic_pkg::B_TIMER_F];
                end
                mic_pkg::OFF_CTRL_HI:
                begin
                    r_d.en[mic_pkg::S_SER]   = reg_wdata[mic_pkg::B_SER_EN];
                    r_d.en[mic_pkg::S_TB]    = reg_wdata[mic_pkg::B_TB_EN];
                    r_d.en[mic_pkg::S_EE]    = reg_wdata[mic_pkg::B_EE_EN];
                    r_d.en[mic_pkg::S_ADC]   = reg_wdata[mic_pkg::B_ADC_EN];
                    r_d.flag[mic_pkg::S_SER] = reg_wdata[mic_pkg::B_SER_F];
                    r_d.flag[mic_pkg::S_TB]  = reg_wdata[mic_pkg::B_TB_F];
                    r_d.flag[mic_pkg::S_EE]  = reg_wdata[mic_pkg::B_EE_F];
                    r_d.flag[mic_pkg::S_ADC] = reg_wdata[mic_pkg::B_ADC_F];
                end
                mic_pkg::OFF_EDGE: r_d.edge_sel = reg_wdata[1:0];
                mic_pkg::OFF_MASK: r_d.mask = reg_wdata[NSRC-1:0];
                default: ;
            endcase
        end

        // Register reads; status clears on read
        if (reg_rd)
        begin
            case (reg_addr)
                mic_pkg::OFF_CTRL_LO: r_d.rdata = lo_v;
                mic_pkg::OFF_CTRL_HI: r_d.rdata = hi_v;
                mic_pkg::OFF_EDGE:    r_d.rdata = {6'h00, r_q.edge_sel};
                mic_pkg::OFF_STATUS:
                begin
                    r_d.rdata  = {1'b0, r_q.sticky};
                    r_d.sticky = '0;
                end
                mic_pkg::OFF_MASK:    r_d.rdata = {1'b0, r_q.mask};
                default:              r_d.rdata = 8'h00;
            endcase
        end

        // Requests gated by enables; global enable and stack room gate the take below
        req = r_q.flag & r_q.en;

        // Acknowledge sequencer; the busy states block a new take so
        // the push and the vector load of one service never overlap
        case (r_q.st)
            mic_pkg::MIC_IDLE:
            begin
                if (r_q.gie && |req && !stack_full && cpu_irq_ready)
                begin
                    r_d.win   = mic_pick(req);
                    r_d.push  = 1'b1;
                    r_d.pdata = cpu_pc;
                    r_d.gie   = 1'b0;
                    r_d.flag[mic_pick(req)] = 1'b0;
                    r_d.st    = mic_pkg::MIC_PUSH;
                end
                else if (return_from_irq)
                    r_d.pop = 1'b1;
            end
            mic_pkg::MIC_PUSH:
            begin
                r_d.load = 1'b1;
                r_d.vec  = mic_vec(r_q.win);
                r_d.st   = mic_pkg::MIC_LOAD;
            end
            mic_pkg::MIC_LOAD: r_d.st = mic_pkg::MIC_IDLE;
            default:           r_d.st = mic_pkg::MIC_IDLE;
        endcase

        // Hardware set wins over any clear this cycle
        r_d.flag   = r_d.flag | ev;
        r_d.sticky = r_d.sticky | ev;
        // Only a flag that newly sets wakes the core, so a flag set
        // beforehand keeps its source quiet; held until low power ends
        // as a level, so a slowly waking core cannot miss it
        r_d.wake   = low_power & (r_q.wake | |(ev & ~r_q.flag));
        r_d.irq    = |(r_d.sticky & r_d.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset gives the idle state and clears every flag and output
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_q          <= '0;
            r_q.st       <= mic_pkg::MIC_IDLE;
            r_q.edge_sel <= mic_pkg::RST_EDGE;
        end
        else
            r_q <= r_d;
    end

    // Every output comes straight from the state register
    assign reg_rdata = r_q.rdata;
    assign stack_push = r_q.push;
    assign push_data = r_q.pdata;
    assign pc_load   = r_q.load;
    assign pc_vector = r_q.vec;
    assign stack_pop = r_q.pop;
    assign wake_up   = r_q.wake;
    assign irq       = r_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // A push is always followed by the vector load
    a_push_then_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        stack_push |=> pc_load)
        else $error("load missing after push");

    // Global enable low means no push on the next edge
    a_gie_blocks: assert property (
        @(posedge clk) disable iff (sys_rst)
        !r_q.gie |=> !stack_push)
        else $error("push with gie low");

    // A full stack refuses every acknowledge
    a_full_blocks: assert property (
        @(posedge clk) disable iff (sys_rst)
        stack_full |=> !stack_push)
        else $error("push with stack full");

    // Servicing drops the global enable
    a_gie_cleared: assert property (
        @(posedge clk) disable iff (sys_rst)
        stack_push |-> !r_q.gie)
        else $error("gie kept on service");

    // A timer event sets its flag whatever the enables hold
    a_event_sets: assert property (
        @(posedge clk) disable iff (sys_rst)
        timer_event |=> r_q.flag[mic_pkg::S_TIMER])
        else $error("flag lost");

    // No enabled source means no jump
    a_no_enable: assert property (
        @(posedge clk) disable iff (sys_rst)
        (r_q.en == '0) |=> !stack_push)
        else $error("jump without enable");

    // The pushed word is the address the core showed at the take
    a_push_pc: assert property (
        @(posedge clk) disable iff (sys_rst)
        stack_push |-> push_data == $past(cpu_pc))
        else $error("bad push");

    // A newly set flag in low power raises the wake output
    a_wake_flag: assert property (
        @(posedge clk) disable iff (sys_rst)
        (low_power && |(ev & ~r_q.flag)) |=> wake_up)
        else $error("no wake");

    // Wake is only ever shown in low power
    a_wake_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        !low_power |=> !wake_up)
        else $error("wake outside low power");

    // A pop answers a return request only
    a_pop_return: assert property (
        @(posedge clk) disable iff (sys_rst)
        stack_pop |-> $past(return_from_irq))
        else $error("pop without return");

    // No pending enabled source below the winner
    a_lowest_wins: assert property (
        @(posedge clk) disable iff (sys_rst)
        stack_push |-> ($past(req) & ~({NSRC{1'b1}} << r_q.win)) == '0)
        else $error("lower source skipped");

    // The vector load is a single pulse
    a_load_once: assert property (
        @(posedge clk) disable iff (sys_rst)
        pc_load |=> !pc_load)
        else $error("load longer than one cycle");

    // Back-to-back pushes would nest without software consent
    a_push_once: assert property (
        @(posedge clk) disable iff (sys_rst)
        stack_push |=> !stack_push)
        else $error("push repeated");

    // No new take while the vector load is in flight
    a_take_gap: assert property (
        @(posedge clk) disable iff (sys_rst)
        pc_load |=> !stack_push)
        else $error("take during load");

    // A taken timer source loses its flag unless it fires again
    a_auto_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        (stack_push && r_q.win == 3'(mic_pkg::S_TIMER) && !$past(timer_event))
        |-> !r_q.flag[mic_pkg::S_TIMER])
        else $error("flag kept on service");

    // The top bit of the low control byte reads as zero
    a_bit7_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == mic_pkg::OFF_CTRL_LO) |=> !reg_rdata[7])
        else $error("unused bit read high");

    // A selected pin edge sets the pin flag
    a_pin_sets: assert property (
        @(posedge clk) disable iff (sys_rst)
        pin_edge |=> r_q.flag[mic_pkg::S_PIN])
        else $error("pin flag lost");

endmodule : mic_irq_ctrl

/* File: dv/mic_cpu_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// CPU core stand-in: program counter and return stack
// ---------------------------------------------------------------
module mic_cpu_model #(
    parameter int          DEPTH = 2,
    parameter logic [12:0] PC0   = 13'h0100
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        stack_push,
    input  wire logic [12:0] push_data,
    input  wire logic        pc_load,
    input  wire logic [12:0] pc_vector,
    input  wire logic        stack_pop,
    output logic      [12:0] cpu_pc,
    output logic             stack_full
);
    logic [12:0] stk [DEPTH];
    int          depth;

    // Full is a level, so one pop frees the controller at once
    assign stack_full = (depth == DEPTH);

    // Push, vector load and pop; a shallow stack makes full easy to hit
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            depth  <= 0;
            cpu_pc <= PC0;
        end
        else
        begin
            if (stack_push && depth < DEPTH)
            begin
                stk[depth] <= push_data;
                depth      <= depth + 1;
            end
            else if (stack_pop && depth > 0)
            begin
                cpu_pc <= stk[depth-1];
                depth  <= depth - 1;
            end
            if (pc_load)
                cpu_pc <= pc_vector;
        end
    end
endmodule : mic_cpu_model

/* File: dv/mic_irq_ctrl_tb.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Interrupt controller bench
// ---------------------------------------------------------------
module mic_irq_ctrl_tb;
    localparam logic [12:0] P0 = 13'h0100;
    localparam logic [3:0]  LO = mic_pkg::OFF_CTRL_LO;
    localparam logic [3:0]  HI = mic_pkg::OFF_CTRL_HI;
    localparam logic [3:0]  EG = mic_pkg::OFF_EDGE;
    localparam logic [3:0]  ST = mic_pkg::OFF_STATUS;
    localparam logic [3:0]  MK = mic_pkg::OFF_MASK;
    logic        clk, sys_rst, reg_wr, reg_rd, pin_in, low_power, ret, rdy;
    logic        stack_full, stack_push, pc_load, stack_pop, wake_up, irq;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [6:1]  evt;
    logic [12:0] cpu_pc, push_data, pc_vector;
    int          mismatches = 0;
    int          cmp_count = 0;

    mic_irq_ctrl dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .pin_in, .touch_event(evt[1]),
        .timer_event(evt[2]), .serial_event(evt[3]),
        .timebase_event(evt[4]), .eeprom_event(evt[5]),
        .converter_event(evt[6]), .cpu_pc, .cpu_irq_ready(rdy),
        .stack_full, .return_from_irq(ret), .low_power, .stack_push,
        .push_data, .pc_load, .pc_vector, .stack_pop, .wake_up, .irq);
    mic_cpu_model cpu (.clk, .sys_rst, .stack_push, .push_data, .pc_load,
        .pc_vector, .stack_pop, .cpu_pc, .stack_full);

    // ---------------------------------------------------------------
    // Bus, event and compare helpers
    // ---------------------------------------------------------------
    task chk(input string n, input logic [12:0] e, input logic [12:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clk); reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk); reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task ev(input logic [6:1] m);
        @(posedge clk); evt <= m;
        @(posedge clk); evt <= '0;
    endtask : ev
    // Pulses are seen only just after an edge, so poll there
    task take(input logic [12:0] v, input logic [12:0] p);
        logic s;
        logic q;
        s = 1'b0;
        q = 1'b0;
        repeat (8)
        begin
            #1;
            if (stack_push === 1'b1)
                q = 1'b1;
            if (pc_load === 1'b1 && !s)
            begin
                s = 1'b1;
                chk("pc_vector", v, pc_vector);
                chk("push_data", p, push_data);
            end
            @(posedge clk);
        end
        chk("pc_load", 1'b1, s);
        chk("stack_push", 1'b1, q);
    endtask : take
    task none;
        repeat (8)
        begin
            #1 chk("pc_load", 1'b0, pc_load);
            @(posedge clk);
        end
    endtask : none
    // Returns as soon as the pop shows, so a following take is not missed
    task ret_irq;
        logic s;
        int   n;
        s = 1'b0;
        n = 0;
        @(posedge clk); ret <= 1'b1;
        @(posedge clk); ret <= 1'b0;
        while (n < 4 && !s)
        begin
            #1 s = (stack_pop === 1'b1);
            if (!s) @(posedge clk);
            n++;
        end
        chk("stack_pop", 1'b1, s);
    endtask : ret_irq

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task t_regs;
        rd(LO, d); chk("ctrl_lo", mic_pkg::RST_CTRL_LO, d);
        rd(HI, d); chk("ctrl_hi", mic_pkg::RST_CTRL_HI, d);
        rd(EG, d); chk("edge", mic_pkg::RST_EDGE, d);
        wr(HI, 8'hf0); rd(HI, d); chk("ctrl_hi", 8'hf0, d);
        wr(LO, 8'h80); rd(LO, d); chk("ctrl_lo", 8'h00, d);
        wr(HI, 8'h00); rd(4'h7, d); chk("unmapped", 8'h00, d);
    endtask : t_regs
    task t_flags;
        wr(MK, 8'h04);
        low_power <= 1'b1;
        ev(6'b000010);
        repeat (2) @(posedge clk);
        #1 chk("wake_up", 1'b1, wake_up);
        chk("irq", 1'b1, irq);
        rd(LO, d); chk("ctrl_lo", 8'h40, d);
        wr(LO, 8'h48); none;
        wr(LO, 8'h41); none;
        rd(ST, d); chk("status", 8'h04, d);
        @(posedge clk); low_power <= 1'b0;
        #1 chk("irq", 1'b0, irq);
        rd(ST, d); chk("status", 8'h00, d);
        // A flag set before low power keeps its source from waking
        wr(LO, 8'h40); low_power <= 1'b1; ev(6'b000010);
        repeat (2) @(posedge clk);
        #1 chk("wake_up", 1'b0, wake_up);
        rd(ST, d); chk("status", 8'h04, d);
        @(posedge clk); low_power <= 1'b0;
        wr(LO, 8'h00);
    endtask : t_flags
    // Nests twice to fill the two-deep stack, then unwinds it
    task t_take;
        wr(LO, 8'h09); ev(6'b000010);
        take(mic_pkg::VEC_TIMER, P0);
        rd(LO, d); chk("ctrl_lo", 8'h08, d);
        ev(6'b000010); none;
        rd(LO, d); chk("ctrl_lo", 8'h48, d);
        wr(LO, 8'h49); take(mic_pkg::VEC_TIMER, mic_pkg::VEC_TIMER);
        wr(LO, 8'h09); ev(6'b000010); none;
        ret_irq; take(mic_pkg::VEC_TIMER, mic_pkg::VEC_TIMER);
        ret_irq; ret_irq;
        @(posedge clk);
        #1 chk("cpu_pc", P0, cpu_pc);
        wr(LO, 8'h00);
    endtask : t_take
    task t_prio;
        wr(HI, 8'h01); wr(LO, 8'h04); ev(6'b000101);
        rdy <= 1'b0;
        wr(LO, 8'h25); none;
        rdy <= 1'b1;
        take(mic_pkg::VEC_TOUCH, P0);
        ret_irq;
        wr(LO, 8'h05); take(mic_pkg::VEC_MULTI, P0);
        rd(HI, d); chk("ctrl_hi", 8'h01, d);
        ret_irq; wr(HI, 8'h00); wr(LO, 8'h00);
    endtask : t_prio
    // Every trigger code against one rising and one falling pin edge
    task t_edges;
        for (int s = 0; s < 4; s++)
        begin
            wr(EG, 8'(s)); wr(LO, 8'h00);
            pin_in <= 1'b1;
            repeat (5) @(posedge clk);
            rd(LO, d); chk("pin_rise", s[0], d[4]);
            wr(LO, 8'h00);
            pin_in <= 1'b0;
            repeat (5) @(posedge clk);
            rd(LO, d); chk("pin_fall", s[1], d[4]);
        end
    endtask : t_edges
    // Mid-run reset drops pending flags, status and the interrupt
    task t_reset;
        wr(HI, 8'hf0); wr(MK, 8'h7f); ev(6'b111111);
        #1 chk("irq", 1'b1, irq);
        @(posedge clk); sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk("irq", 1'b0, irq);
        rd(HI, d); chk("ctrl_hi", mic_pkg::RST_CTRL_HI, d);
        rd(ST, d); chk("status", 8'h00, d);
    endtask : t_reset

    // ---------------------------------------------------------------
    // Clock, reset, sequence and verdict
    // ---------------------------------------------------------------
    task conclude;
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        {sys_rst, reg_wr, reg_rd, pin_in, low_power, ret} = 6'b100000;
        rdy = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        evt = '0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs; t_flags; t_take; t_prio; t_edges; t_reset;
        conclude;
    end
    // The whole run needs a few hundred cycles; far more means a hang
    initial
    begin
        #100000;
        mismatches++;
        conclude;
    end
endmodule : mic_irq_ctrl_tb
